// ---- shared/mq_fifo_consts.vh ----
// constants for the multi-queue flow fifo: sizes, widths, reset values.
// assumes inclusion by the single design file; definitions only.
//
// How it works
// - one shared 40-bit write bus and one shared 40-bit read bus.
// - one to 128 queues carved out of a single shared memory.
// - writes steered to selected write queue, reads muxed from read queue.
// - write and read ports act independently of each other.
// - both ports may select different queues or the same queue.
// - full flag for write queue, empty flag for read queue.
// - every queue has its own settable almost-full and almost-empty level.
// - two 8-bit status buses report almost-full and almost-empty of queues.
// - up to eight queues one line each, more queues time-multiplexed.
// - status bus multiplexing selectable polled or direct.
// - each port 20 or 40 bits wide, word order kept.
// - parity bits pass through as plain data, no checking.
// - standard mode reader drains pipelined word on switch; back-off-one need not.
// - back-off-one mode keeps unread pipelined word until actually read.
// - write and read ports each set a mark in their own queue.
// - rewind to mark drops written data or makes read data readable again.
// - queue count comes from the cfg_queue_log2 strap at reset: 128 equal queues only when it is 7.
// - whole memory may form one single queue.
// - master reset captures setup inputs, must precede programming.
// - queues built from whole blocks of 256 forty-bit words.
// - writes only take effect while selected write queue not full.
// - switching read to empty queue keeps last word on output.
// - standard mode delivers one word per enabled read cycle.
`ifndef MQ_FIFO_CONSTS_VH
`define MQ_FIFO_CONSTS_VH
`define DATA_W       40
`define HALF_W       20
`define NUM_Q        128
`define QID_W        7
`define BLOCK_WORDS  256
`define NUM_BLOCKS   512
`define ADDR_W       17
`define PTR_W        18
`define GRP_W        4
`define MEM_WORDS    131072
`define TOTAL_WORDS  18'h2_0000
`define DEF_QLOG     3'h7
`define DEF_AF_OFF   18'h0_0010
`define DEF_AE_OFF   18'h0_0010
`define PTR_ZERO     18'h0_0000
`define PTR_ONE      18'h0_0001
`endif

// ---- hdl/multi_queue_flow_fifo.v ----
// multi-queue flow fifo: shared memory, per-queue pointers, flags, marks.
// assumes all inputs come from logic on core_clk; setup straps held
// steady while rst_b is low.
`timescale 1ns/100ps
`include "mq_fifo_consts.vh"
module multi_queue_flow_fifo (
   input  wire                core_clk,
   input  wire                rst_b,
   input  wire [2:0]          cfg_queue_log2,
   input  wire                cfg_boi,
   input  wire                cfg_wr_x20,
   input  wire                cfg_rd_x20,
   input  wire                cfg_status_polled,
   input  wire [6:0]          wr_queue,
   input  wire                wr_en,
   input  wire [39:0]         wr_data,
   input  wire                wr_mark,
   input  wire                wr_rewind,
   input  wire [6:0]          rd_queue,
   input  wire                rd_en,
   input  wire                rd_ready,
   input  wire                rd_mark,
   input  wire                rd_rewind,
   input  wire                thr_we,
   input  wire [6:0]          thr_queue,
   input  wire [17:0]         thr_af_off,
   input  wire [17:0]         thr_ae_off,
   input  wire [3:0]          status_group_sel,
   output reg  [39:0]         rd_data_r,
   output reg                 rd_valid_r,
   output reg                 queue_full_flag_r,
   output reg                 queue_empty_flag_r,
   output reg                 almost_full_flag_r,
   output reg                 almost_empty_flag_r,
   output reg  [7:0]          almost_full_status_bus_r,
   output reg  [7:0]          almost_empty_status_bus_r,
   output reg  [3:0]          status_group_r
);
   // captured setup
   reg  [2:0]                 qlog_r;
   reg                        boi_r;
   reg                        wx20_r;
   reg                        rx20_r;
   reg                        poll_r;
   // shared storage and per-queue state
   reg  [39:0]                mem [0:`MEM_WORDS-1];
   reg  [17:0]                wp [0:`NUM_Q-1];
   reg  [17:0]                rp [0:`NUM_Q-1];
   reg  [17:0]                wm [0:`NUM_Q-1];
   reg  [17:0]                rm [0:`NUM_Q-1];
   reg  [17:0]                afo [0:`NUM_Q-1];
   reg  [17:0]                aeo [0:`NUM_Q-1];
   // write side
   reg  [19:0]                half_r;
   reg                        half_v_r;
   reg  [6:0]                 last_wq_r;
   // read side two-entry buffer and output stage
   reg  [39:0]                buf0_r;
   reg  [39:0]                buf1_r;
   reg  [1:0]                 bcnt_r;
   reg                        hsel_r;
   reg  [6:0]                 last_rq_r;
   reg  [3:0]                 grp_r;
   integer                    k;

   // queue size in words: memory split evenly by power of two
   wire [17:0] qsize  = `TOTAL_WORDS >> qlog_r;
   wire [6:0]  qmask  = ~(7'h7f << qlog_r);
   wire [17:0] offmsk = qsize - `PTR_ONE;
   wire [3:0]  gmask  = qmask[6:3];

   // demux/mux by selected queue, masked to the configured count
   wire [6:0]  wq     = wr_queue & qmask;
   wire [6:0]  rq     = rd_queue & qmask;
   wire [23:0] wbase  = {wq, 17'h0_0000} >> qlog_r;
   wire [23:0] rbase  = {rq, 17'h0_0000} >> qlog_r;
   wire [17:0] woff   = wp[wq] & offmsk;
   wire [17:0] roff   = rp[rq] & offmsk;
   wire [16:0] waddr  = wbase[16:0] | woff[16:0];
   wire [16:0] raddr  = rbase[16:0] | roff[16:0];

   // fill levels of the two selected queues
   wire [17:0] wfill  = wp[wq] - rp[wq];
   wire [17:0] rfill  = wp[rq] - rp[rq];
   wire [17:0] wsince = wp[wq] - wm[wq];
   wire [17:0] rsince = wp[rq] - rm[rq];
   wire        wfull  = (wfill == qsize);
   wire        rempty = (rfill == `PTR_ZERO);

   // x20 write: first half is upper bits, second half completes the word
   wire        wsw    = (wq != last_wq_r);
   wire        wword  = wr_en & (~wx20_r | (half_v_r & ~wsw));
   wire [39:0] wdata  = wx20_r ? {half_r, wr_data[19:0]} : wr_data;
   // a word to a full queue is refused outright
   wire        do_wr  = wword & ~wfull & ~wr_rewind;
   // write rewind only while the marked data has not been read out; read rewind while data since the mark fits in the queue
   wire        wrw_ok = wr_rewind & (wsince <= wfill);
   wire        rrw_ok = rd_rewind & (rsince <= qsize);

   // read side control
   wire        rsw    = (rq != last_rq_r);
   // back-off-one drops unread buffered words and backs the pointer off
   wire        discard = boi_r & rsw;
   // fetch stalls on empty queue, full buffer or queue switch
   wire        fetch  = rd_en & ~rempty & (bcnt_r != 2'h2) & ~rsw & ~rd_rewind;
   wire        beat   = rd_ready & (bcnt_r != 2'h0) & ~discard;
   wire        pop    = beat & (~rx20_r | hsel_r);
   wire [39:0] rword  = mem[raddr];

   // master reset latches the setup straps; one core clock for both ports
   always @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         qlog_r <= cfg_queue_log2;
         boi_r  <= cfg_boi;
         wx20_r <= cfg_wr_x20;
         rx20_r <= cfg_rd_x20;
         poll_r <= cfg_status_polled;
      end
   end

   // storage holds all 40 bits as given, parity included
   always @(posedge core_clk)
   begin
      if (do_wr)
         mem[waddr] <= wdata;
   end

   // write pointers: rewind beats a write in the same cycle
   always @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         for (k = 0; k < `NUM_Q; k = k + 1)
            wp[k] <= `PTR_ZERO;
      end
      else if (wrw_ok)
         wp[wq] <= wm[wq];
      else if (do_wr)
         wp[wq] <= wp[wq] + `PTR_ONE;
   end

   // marks taken from the live pointer of each port's queue
   always @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         for (k = 0; k < `NUM_Q; k = k + 1)
         begin
            wm[k] <= `PTR_ZERO;
            rm[k] <= `PTR_ZERO;
         end
      end
      else
      begin
         if (wr_mark)
            wm[wq] <= wp[wq];
         if (rd_mark)
            rm[rq] <= rp[rq];
      end
   end

   // read pointers: back-off, then rewind, then fetch
   always @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         for (k = 0; k < `NUM_Q; k = k + 1)
            rp[k] <= `PTR_ZERO;
      end
      else if (discard)
         rp[last_rq_r] <= rp[last_rq_r] - {16'h0000, bcnt_r};
      else if (rrw_ok)
         rp[rq] <= rm[rq];
      else if (fetch)
         rp[rq] <= rp[rq] + `PTR_ONE;
   end

   // per-queue thresholds, defaults until software loads them
   always @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         for (k = 0; k < `NUM_Q; k = k + 1)
         begin
            afo[k] <= `DEF_AF_OFF;
            aeo[k] <= `DEF_AE_OFF;
         end
      end
      else if (thr_we)
      begin
         afo[thr_queue] <= thr_af_off;
         aeo[thr_queue] <= thr_ae_off;
      end
   end

   // x20 half assembler; a queue switch drops a lone half
   always @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         half_r    <= 20'h0_0000;
         half_v_r  <= 1'b0;
         last_wq_r <= 7'h00;
      end
      else
      begin
         last_wq_r <= wq;
         if (!wx20_r || wsw)
            half_v_r <= 1'b0;
         else if (wr_en && !half_v_r)
         begin
            half_r   <= wr_data[19:0];
            half_v_r <= 1'b1;
         end
         else if (do_wr)
            half_v_r <= 1'b0;
      end
   end

   // two-entry buffer; in standard mode old words still drain after switch
   always @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         buf0_r    <= 40'h00_0000_0000;
         buf1_r    <= 40'h00_0000_0000;
         bcnt_r    <= 2'h0;
         last_rq_r <= 7'h00;
      end
      else
      begin
         last_rq_r <= rq;
         if (discard)
            bcnt_r <= 2'h0;
         else if (fetch && !pop)
         begin
            if (bcnt_r == 2'h0)
               buf0_r <= rword;
            else
               buf1_r <= rword;
            bcnt_r <= bcnt_r + 2'h1;
         end
         else if (pop && !fetch)
         begin
            buf0_r <= buf1_r;
            bcnt_r <= bcnt_r - 2'h1;
         end
         else if (pop && fetch)
         begin
            if (bcnt_r == 2'h1)
               buf0_r <= rword;
            else
            begin
               buf0_r <= buf1_r;
               buf1_r <= rword;
            end
         end
      end
   end

   // output register keeps its last word whenever nothing new arrives
   always @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         rd_data_r  <= 40'h00_0000_0000;
         rd_valid_r <= 1'b0;
         hsel_r     <= 1'b0;
      end
      else
      begin
         rd_valid_r <= beat;
         if (discard)
            hsel_r <= 1'b0;
         else if (beat && !rx20_r)
            rd_data_r <= buf0_r;
         else if (beat && !hsel_r)
         begin
            rd_data_r <= {20'h0_0000, buf0_r[39:20]};
            hsel_r    <= 1'b1;
         end
         else if (beat)
         begin
            rd_data_r <= {20'h0_0000, buf0_r[19:0]};
            hsel_r    <= 1'b0;
         end
      end
   end

   // selected-queue flags, registered one cycle behind the pointers
   always @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         queue_full_flag_r   <= 1'b0;
         queue_empty_flag_r  <= 1'b1;
         almost_full_flag_r  <= 1'b0;
         almost_empty_flag_r <= 1'b1;
      end
      else
      begin
         queue_full_flag_r   <= wfull;
         almost_full_flag_r  <= (wfill >= qsize - afo[wq]);
         queue_empty_flag_r  <= rempty;
         almost_empty_flag_r <= (rfill <= aeo[rq]);
      end
   end

   // eight queues of the current group evaluated side by side
   wire [7:0] af_w;
   wire [7:0] ae_w;
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1)
      begin : stat
         localparam [2:0] LANE = g;
         wire [6:0]  qi = {grp_r[3:0], LANE} & qmask;
         wire        ok = (qi == {grp_r[3:0], LANE});
         wire [17:0] fl = wp[qi] - rp[qi];
         assign af_w[g] = ok & (fl >= qsize - afo[qi]);
         assign ae_w[g] = ok & (fl <= aeo[qi]);
      end
   endgenerate

   // polled rotates through groups; direct follows the select input
   always @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         grp_r                     <= 4'h0;
         status_group_r            <= 4'h0;
         almost_full_status_bus_r  <= 8'h00;
         almost_empty_status_bus_r <= 8'h00;
      end
      else
      begin
         if (poll_r)
            grp_r <= (grp_r + 4'h1) & gmask;
         else
            grp_r <= status_group_sel & gmask;
         status_group_r            <= grp_r;
         almost_full_status_bus_r  <= af_w;
         almost_empty_status_bus_r <= ae_w;
      end
   end
endmodule

// ---- tb/multi_queue_flow_fifo_chk.sv ----
// port-level checker for the multi-queue flow fifo.
// assumes one clock, synchronous active-low reset, bound below.
`timescale 1ns/100ps
module multi_queue_flow_fifo_chk (
   input wire        core_clk,
   input wire        rst_b,
   input wire [2:0]  cfg_queue_log2,
   input wire        cfg_rd_x20,
   input wire        cfg_status_polled,
   input wire        wr_en,
   input wire [6:0]  rd_queue,
   input wire        rd_ready,
   input wire        rd_rewind,
   input wire [3:0]  status_group_sel,
   input wire [39:0] rd_data_r,
   input wire        rd_valid_r,
   input wire        queue_full_flag_r,
   input wire        queue_empty_flag_r,
   input wire        almost_full_flag_r,
   input wire        almost_empty_flag_r,
   input wire [3:0]  status_group_r
);
   // all checks on the one clock domain
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   AST_BEAT_READY: assert property (rd_valid_r |-> $past(rd_ready))
      else $error("beat without receiver ready");
   AST_DATA_HOLD: assert property (!rd_valid_r && $past(rst_b) |-> $stable(rd_data_r))
      else $error("output word moved without a beat");
   AST_EMPTY_AE: assert property (queue_empty_flag_r |-> almost_empty_flag_r)
      else $error("empty without almost empty");
   AST_FULL_AF: assert property (queue_full_flag_r |-> almost_full_flag_r)
      else $error("full without almost full");
   AST_GROUP_DIRECT: assert property (!cfg_status_polled && $past(rst_b)
      && cfg_queue_log2 == 3'h7 |=> status_group_r == $past(status_group_sel, 2))
      else $error("direct group not followed");
   AST_GROUP_SMALL: assert property (cfg_queue_log2 <= 3'h3
      |-> status_group_r == 4'h0)
      else $error("group moved with eight or fewer queues");
   AST_NARROW_UPPER: assert property (cfg_rd_x20 && rd_valid_r
      |-> rd_data_r[39:20] == 20'h0_0000)
      else $error("narrow read upper half not zero");
   // idle empty queue must stay empty: no read side effects
   AST_EMPTY_STEADY: assert property (queue_empty_flag_r && $past(rst_b)
      && !wr_en && !$past(wr_en) && !rd_rewind && !$past(rd_rewind)
      && rd_queue == $past(rd_queue) |=> queue_empty_flag_r)
      else $error("empty queue became non-empty without a write");
endmodule

bind multi_queue_flow_fifo multi_queue_flow_fifo_chk u_chk (.*);

// ---- tb/rd_sink.sv ----
// downstream receiver model: gives ready, stalls on request.
// assumes the bench raises stall to slow it down.
`timescale 1ns/100ps
module rd_sink (
   input  wire core_clk,
   input  wire stall,
   output reg  rd_ready
);
   reg [1:0] ph_r;
   initial
   begin
      rd_ready = 1'h0;
      ph_r = 2'h0;
   end
   // stalling still lets one beat in four through, so no hang
   always @(negedge core_clk)
   begin
      ph_r = ph_r + 2'h1;
      rd_ready = !stall || (ph_r == 2'h0);
   end
endmodule

// ---- tb/multi_queue_flow_fifo_bench.sv ----
// self-checking bench for the multi-queue flow fifo.
// assumes rd_sink as receiver; inputs change at the falling edge.
`timescale 1ns/100ps
module multi_queue_flow_fifo_bench;
   reg         core_clk, rst_b, cfg_boi, cfg_wr_x20, cfg_rd_x20;
   reg         cfg_status_polled, wr_en, wr_mark, wr_rewind, rd_en;
   reg         rd_mark, rd_rewind, thr_we, stall;
   reg  [2:0]  cfg_queue_log2;
   reg  [3:0]  status_group_sel;
   reg  [6:0]  wr_queue, rd_queue, thr_queue;
   reg  [17:0] thr_af_off, thr_ae_off;
   reg  [39:0] wr_data;
   reg  [46:0] rows [0:3];
   wire        rd_ready, rd_valid_r, queue_full_flag_r, queue_empty_flag_r;
   wire        almost_full_flag_r, almost_empty_flag_r;
   wire [3:0]  status_group_r;
   wire [7:0]  almost_full_status_bus_r, almost_empty_status_bus_r;
   wire [39:0] rd_data_r;
   integer     err_total, check_count, i;

   multi_queue_flow_fifo u_dut (.*);
   rd_sink u_sink (.core_clk(core_clk), .stall(stall), .rd_ready(rd_ready));

   task chk(input [39:0] seen, input [39:0] exp);
   begin
      check_count = check_count + 1;
      if (seen !== exp)
      begin
         err_total = err_total + 1;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   end
   endtask
   task tick(input integer n);
      repeat (n) @(negedge core_clk);
   endtask
   task wr(input [6:0] q, input [39:0] d);
   begin
      wr_queue = q;
      wr_data = d;
      wr_en = 1'h1;
      tick(1);
   end
   endtask
   // queue held two cycles first: the switch cycle never fetches
   task fetch(input [6:0] q);
   begin
      rd_queue = q;
      tick(2);
      rd_en = 1'h1;
      tick(1);
      rd_en = 1'h0;
   end
   endtask
   task beat(input [39:0] exp);
      integer k;
   begin
      k = 0;
      while (rd_valid_r !== 1'h1 && k < 32)
      begin
         tick(1);
         k = k + 1;
      end
      chk(rd_data_r, exp);
      tick(1);
   end
   endtask
   task print_verdict;
   begin
      if (err_total == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   end
   endtask

   initial
   begin
      core_clk = 1'h0;
      forever #25 core_clk = ~core_clk;
   end
   // watchdog well past the expected ten thousand cycles
   initial
   begin
      #4_000_000;
      err_total = err_total + 1;
      print_verdict;
   end

   initial
   begin
      err_total = 0;
      check_count = 0;
      {rst_b, cfg_boi, cfg_wr_x20, cfg_rd_x20, cfg_status_polled} = 5'h00;
      {wr_en, wr_mark, wr_rewind, rd_en, rd_mark, rd_rewind} = 6'h00;
      {thr_we, stall, wr_queue, rd_queue, thr_queue} = 23'h00_0000;
      {thr_af_off, wr_data} = 58'h000_0000_0000_0000;
      thr_ae_off = 18'h0_0010;
      cfg_queue_log2 = 3'h7;
      status_group_sel = 4'h1;
      rows[0] = {7'h00, 40'h00_0000_0001};
      rows[1] = {7'h7F, 40'hFF_FFFF_FFFF};
      rows[2] = {7'h05, 40'hA5_5A5A_A55A};
      rows[3] = {7'h05, 40'h0F_0F0F_F0F0};
      tick(20);
      chk({rd_valid_r, queue_full_flag_r, queue_empty_flag_r}, 3'h1);
      chk({almost_full_flag_r, almost_empty_flag_r}, 2'h1);
      chk(rd_data_r, 40'h00_0000_0000);
      chk({almost_full_status_bus_r, status_group_r}, 12'h000);
      chk(almost_empty_status_bus_r, 8'h00);
      rst_b = 1'h1;
      tick(2);
      // words land in their own queues in order
      for (i = 0; i < 4; i = i + 1)
         wr(rows[i][46:40], rows[i][39:0]);
      wr_en = 1'h0;
      for (i = 0; i < 4; i = i + 1)
      begin
         fetch(rows[i][46:40]);
         beat(rows[i][39:0]);
      end
      // almost full at exactly size minus offset
      thr_queue = 7'h09;
      thr_af_off = 18'h0_0200;
      thr_we = 1'h1;
      tick(1);
      thr_we = 1'h0;
      for (i = 0; i < 511; i = i + 1)
         wr(7'h09, {8'h00, i});
      wr_en = 1'h0;
      tick(3);
      chk(almost_full_flag_r, 1'h0);
      wr(7'h09, {8'h00, 32'd511});
      wr_en = 1'h0;
      tick(3);
      chk(almost_full_flag_r, 1'h1);
      chk(almost_full_status_bus_r, 8'h02);
      chk(almost_empty_status_bus_r, 8'hFD);
      // queue of 1024 words fills, extra write dropped
      for (i = 512; i < 1024; i = i + 1)
         wr(7'h09, {8'h00, i});
      wr_en = 1'h0;
      tick(3);
      chk(queue_full_flag_r, 1'h1);
      wr(7'h09, 40'hFF_FFFF_FFFF);
      wr_en = 1'h0;
      stall = 1'h1;
      for (i = 0; i < 1024; i = i + 1)
      begin
         fetch(7'h09);
         beat({8'h00, i});
      end
      stall = 1'h0;
      tick(3);
      chk(queue_empty_flag_r, 1'h1);
      chk(almost_empty_flag_r, 1'h1);
      // switch to an empty queue keeps the last word
      fetch(7'h14);
      tick(6);
      chk(rd_valid_r, 1'h0);
      chk(rd_data_r, 40'h00_0000_03FF);
      // mark, read two, rewind, read all three again
      for (i = 0; i < 3; i = i + 1)
         wr(7'h02, {8'hC0, i});
      wr_en = 1'h0;
      rd_queue = 7'h02;
      tick(2);
      rd_mark = 1'h1;
      tick(1);
      rd_mark = 1'h0;
      for (i = 0; i < 2; i = i + 1)
      begin
         fetch(7'h02);
         beat({8'hC0, i});
      end
      rd_rewind = 1'h1;
      tick(1);
      rd_rewind = 1'h0;
      for (i = 0; i < 3; i = i + 1)
      begin
         fetch(7'h02);
         beat({8'hC0, i});
      end
      // write mark then rewind drops the word written since
      wr_queue = 7'h03;
      wr_mark = 1'h1;
      tick(1);
      wr_mark = 1'h0;
      wr(7'h03, 40'hAA_0000_0001);
      wr_en = 1'h0;
      wr_rewind = 1'h1;
      tick(1);
      wr_rewind = 1'h0;
      wr(7'h03, 40'hBB_0000_0002);
      wr_en = 1'h0;
      fetch(7'h03);
      beat(40'hBB_0000_0002);
      // one queue, narrow read; later strap change ignored
      rst_b = 1'h0;
      cfg_queue_log2 = 3'h0;
      cfg_rd_x20 = 1'h1;
      cfg_status_polled = 1'h1;
      tick(3);
      rst_b = 1'h1;
      cfg_wr_x20 = 1'h1;
      tick(2);
      wr(7'h55, 40'h12_3456_789A);
      wr_en = 1'h0;
      fetch(7'h2A);
      beat(40'h00_0001_2345);
      beat(40'h00_0006_789A);
      chk(status_group_r, 4'h0);
      print_verdict;
   end
endmodule
